// file: inc/alu_status_pkg.sv
package alu_status_pkg;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned PSW_W    = 8;
  // Status word field positions
  localparam int unsigned PSW_PRIO_HI = 7;
  localparam int unsigned PSW_PRIO_LO = 5;
  localparam int unsigned PSW_TRACE   = 4;
  localparam int unsigned PSW_N       = 3;
  localparam int unsigned PSW_Z       = 2;
  localparam int unsigned PSW_V       = 1;
  localparam int unsigned PSW_C       = 0;
  localparam logic [7:0]  PSW_RESET   = 8'h00;
  localparam logic [15:0] DREG_RESET  = 16'h0000;
  // Data-path output mux selects
  localparam logic [1:0] DMUX_READ_BUS = 2'h0;
  localparam logic [1:0] DMUX_SYS_BUS  = 2'h1;
  localparam logic [1:0] DMUX_SHIFT_R  = 2'h2;
  localparam logic [1:0] DMUX_SHIFT_R3 = 2'h3;
  // Result destination selects
  localparam logic [1:0] DEST_NONE = 2'h0;
  localparam logic [1:0] DEST_DATA = 2'h1;
  localparam logic [1:0] DEST_ADDR = 2'h2;
  localparam logic [1:0] DEST_BOTH = 2'h3;
  // Status-load select codes
  localparam logic [2:0] SLS_HOLD      = 3'h0;
  localparam logic [2:0] SLS_LOAD_MUX  = 3'h1;
  localparam logic [2:0] SLS_CC_ALU    = 3'h2;
  localparam logic [2:0] SLS_CC_NZ     = 3'h3;
  localparam logic [2:0] SLS_CC_DECODE = 3'h4;
  // Data-alteration codes
  localparam logic [1:0] DAD_NONE   = 2'h0;
  localparam logic [1:0] DAD_IR_OP  = 2'h1;

  typedef enum logic [1:0] {
    ALU_SRC_MICROWORD = 2'b00,
    ALU_SRC_IR        = 2'b01
  } alu_src_e;

  typedef struct packed {
    logic [3:0] microword_function_field;
    logic       microword_mode_field;
    logic       carry_in_request;
    logic [1:0] discrete_data_alteration_code;
  } alu_ctrl_s;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } cond_codes_s;
endpackage

// file: core/alu_function_unit.sv
`timescale 1ns/10ps
`default_nettype none
module alu_function_unit (
  // Control
  input  wire logic        i_alu_logic_mode_line,
  input  wire logic [3:0]  i_function_select,
  input  wire logic        i_adder_carry_input,
  // Operands
  input  wire logic [15:0] i_operand_a_input,
  input  wire logic [15:0] i_operand_b_input,
  // Result
  output logic [15:0]      o_result,
  output logic             o_carry_out,
  output logic             o_overflow
);
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] p;
  logic [15:0] q;
  logic [16:0] sum;
  assign a = i_operand_a_input;
  assign b = i_operand_b_input;
  // Arithmetic = P plus Q plus carry; P/Q from the select pattern
  always_comb begin
    unique case (i_function_select)
      4'h0: begin p = a; q = 16'h0000; end               // RULE_05
      4'h1: begin p = a | b; q = 16'h0000; end
      4'h2: begin p = a | ~b; q = 16'h0000; end
      4'h3: begin p = 16'hFFFF; q = 16'h0000; end
      4'h4: begin p = a; q = a & ~b; end
      4'h5: begin p = a | b; q = a & ~b; end
      4'h6: begin p = a; q = ~b; end                     // RULE_07
      4'h7: begin p = a & ~b; q = 16'hFFFF; end
      4'h8: begin p = a; q = a & b; end
      4'h9: begin p = a; q = b; end                      // RULE_06
      4'hA: begin p = a | ~b; q = a & b; end
      4'hB: begin p = a & b; q = 16'hFFFF; end
      4'hC: begin p = a; q = a; end                      // RULE_09
      4'hD: begin p = a | b; q = a; end
      4'hE: begin p = a | ~b; q = a; end
      default: begin p = a; q = 16'hFFFF; end            // RULE_08
    endcase
  end
  assign sum = {1'b0, p} + {1'b0, q} + {16'h0000, i_adder_carry_input};
  always_comb begin
    o_carry_out = 1'b0;
    o_overflow  = 1'b0;
    if (i_alu_logic_mode_line) begin                     // RULE_03
      unique case (i_function_select)
        4'h0: o_result = ~a;                             // RULE_05
        4'h1: o_result = ~(a | b);
        4'h2: o_result = ~a & b;
        4'h3: o_result = 16'h0000;
        4'h4: o_result = ~(a & b);
        4'h5: o_result = ~b;
        4'h6: o_result = a ^ b;
        4'h7: o_result = a & ~b;
        4'h8: o_result = ~a | b;
        4'h9: o_result = ~(a ^ b);
        4'hA: o_result = b;
        4'hB: o_result = a & b;
        4'hC: o_result = 16'hFFFF;
        4'hD: o_result = a | ~b;
        4'hE: o_result = a | b;
        default: o_result = a;                           // RULE_08
      endcase
    end else begin
      o_result    = sum[15:0];                           // RULE_01
      o_carry_out = sum[16];
      o_overflow  = (p[15] == q[15]) && (sum[15] != p[15]);
    end
  end
endmodule
`default_nettype wire

// file: core/alu_status_datapath.sv
// Overview of operation
// (RULE_01) The unit takes two 16-bit operands and gives sixteen logic and sixteen arithmetic functions.
// (RULE_02) Six controls govern it: mode, four function selects and a carry-in from carry logic.
// (RULE_03) Selects, mode and carry-in give 32 operations, and logic mode ignores carry-in.
// (RULE_04) The result is captured in the data register or the bus-address register for later use.
// (RULE_05) Select 0000 gives not A in logic mode, and A or A plus one in arithmetic mode.
// (RULE_06) Select 1001 in arithmetic mode gives A plus B, plus one with carry-in.
// (RULE_07) Select 0110 in arithmetic mode gives A minus B minus one, or A minus B with carry-in.
// (RULE_08) Select 1111 passes A in logic mode, and gives A minus one or A in arithmetic mode.
// (RULE_09) Select 1100 in arithmetic mode shifts A left one place, carry-in adding one.
// (RULE_10) Microword fields drive the unit, except in shared flows where alteration code and IR decide.
// (RULE_11) The status word is 8 bits: priority in 7..5, trace bit, and N, Z, V, C codes.
// (RULE_12) The status word loads whole from the output mux, and condition logic loads the four codes.
// (RULE_13) The status word goes to the system bus on an absolute address, else to the read bus.
// (RULE_14) The status-load select code with decode picks the condition source and the direct load.
// (RULE_15) The read bus is wired-OR, and each attached unit sits between output mux and read bus.
// (RULE_16) A two-bit select steers the output mux to read bus, system bus or data register shifted right.
// (RULE_17) Status and condition updates land on the clock edge that ends the machine state.
`timescale 1ns/10ps
`default_nettype none
module alu_status_datapath (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  // Microword control
  input  wire alu_status_pkg::alu_ctrl_s i_alu_ctrl,
  input  wire logic [1:0]  i_dest_select,
  input  wire logic [1:0]  i_dmux_select,
  input  wire logic [2:0]  i_status_load_select_code,
  // Instruction decode
  input  wire logic [3:0]  i_ir_function_select,
  input  wire logic        i_ir_mode,
  input  wire logic        i_ir_carry_in,
  input  wire alu_status_pkg::cond_codes_s i_decode_cond_codes,
  // Operands and buses
  input  wire logic [15:0] i_operand_a_input,
  input  wire logic [15:0] i_operand_b_input,
  input  wire logic [15:0] i_read_bus,
  input  wire logic [15:0] i_sys_bus_data,
  input  wire logic        i_status_absolute_addr,
  input  wire logic        i_status_read_enable,
  // Results
  output logic [15:0]      o_data_reg,
  output logic [15:0]      o_bus_addr_reg,
  output logic [15:0]      o_dmux,
  output logic [7:0]       o_processor_status_word,
  output logic [15:0]      o_status_to_read_bus,
  output logic [15:0]      o_status_to_sys_bus,
  output logic             o_status_sys_bus_enable
);
  logic                     alu_logic_mode_line;
  logic [3:0]               function_select;
  logic                     adder_carry_input;
  logic [15:0]              alu_result;
  logic                     alu_carry;
  logic                     alu_overflow;
  logic                     data_carry;
  logic [15:0]              next_dmux;
  alu_status_pkg::alu_src_e alu_src;
  alu_status_pkg::cond_codes_s next_cc;
  logic                     cc_load;
  logic                     load_data;
  logic                     load_addr;
  logic                     alu_negative;
  logic                     alu_zero;
  logic [15:0]              status_word_ext;

  // Operation source: microword, or alteration code with IR
  always_comb begin
    if (i_alu_ctrl.discrete_data_alteration_code == alu_status_pkg::DAD_IR_OP) begin
      alu_src = alu_status_pkg::ALU_SRC_IR;                 // RULE_10
    end else begin
      alu_src = alu_status_pkg::ALU_SRC_MICROWORD;
    end
  end

  // Controls handed to the function unit
  always_comb begin
    case (alu_src)
      alu_status_pkg::ALU_SRC_IR: begin
        function_select     = i_ir_function_select;         // RULE_10
        alu_logic_mode_line = i_ir_mode;
        adder_carry_input   = i_ir_carry_in;
      end
      default: begin
        function_select     = i_alu_ctrl.microword_function_field; // RULE_02
        alu_logic_mode_line = i_alu_ctrl.microword_mode_field;
        adder_carry_input   = i_alu_ctrl.carry_in_request;
      end
    endcase
  end

  alu_function_unit u_alu (
    .i_alu_logic_mode_line (alu_logic_mode_line),
    .i_function_select     (function_select),
    .i_adder_carry_input   (adder_carry_input),
    .i_operand_a_input     (i_operand_a_input),
    .i_operand_b_input     (i_operand_b_input),
    .o_result            (alu_result),
    .o_carry_out         (alu_carry),
    .o_overflow          (alu_overflow)
  );

  // Destination decode shared by both result registers
  assign load_data = (i_dest_select == alu_status_pkg::DEST_DATA) ||
                     (i_dest_select == alu_status_pkg::DEST_BOTH);
  assign load_addr = (i_dest_select == alu_status_pkg::DEST_ADDR) ||
                     (i_dest_select == alu_status_pkg::DEST_BOTH);

  // Result capture
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data_reg <= alu_status_pkg::DREG_RESET;
    end else if (load_data) begin
      o_data_reg <= alu_result;                             // RULE_04
    end
  end

  // Carry travels with the data register so the right shift can use it
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_carry <= 1'b0;
    end else if (load_data) begin
      data_carry <= alu_carry;                              // RULE_16
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bus_addr_reg <= alu_status_pkg::DREG_RESET;
    end else if (load_addr) begin
      o_bus_addr_reg <= alu_result;                         // RULE_04
    end
  end

  // Output mux
  always_comb begin
    case (i_dmux_select)
      alu_status_pkg::DMUX_READ_BUS: next_dmux = i_read_bus;      // RULE_16
      alu_status_pkg::DMUX_SYS_BUS:  next_dmux = i_sys_bus_data;
      default: next_dmux = {data_carry, o_data_reg[15:1]};        // RULE_16
    endcase
  end

  // Registered copy drives the outgoing bus
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dmux <= alu_status_pkg::DREG_RESET;
    end else begin
      o_dmux <= next_dmux;
    end
  end

  // Flags of the present ALU result
  assign alu_negative = alu_result[15];
  assign alu_zero     = (alu_result == 16'h0000);

  // Condition source chosen by status-load select code
  always_comb begin
    cc_load = 1'b1;
    next_cc = i_decode_cond_codes;
    case (i_status_load_select_code)
      alu_status_pkg::SLS_CC_ALU: begin                     // RULE_14
        next_cc.n = alu_negative;
        next_cc.z = alu_zero;
        next_cc.v = alu_overflow;
        next_cc.c = alu_carry;
      end
      alu_status_pkg::SLS_CC_NZ: begin
        next_cc.n = alu_negative;
        next_cc.z = alu_zero;
        next_cc.v = 1'b0;
        next_cc.c = o_processor_status_word[alu_status_pkg::PSW_C];
      end
      alu_status_pkg::SLS_CC_DECODE: next_cc = i_decode_cond_codes;
      default: cc_load = 1'b0;
    endcase
  end

  // Status word: whole load from mux or condition-code load
  // A whole load wins over a condition-code load in the same state
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_processor_status_word <= alu_status_pkg::PSW_RESET;
    end else if (i_status_load_select_code == alu_status_pkg::SLS_LOAD_MUX) begin
      o_processor_status_word <= next_dmux[7:0];            // RULE_12 RULE_17
    end else if (cc_load) begin
      o_processor_status_word[alu_status_pkg::PSW_N:alu_status_pkg::PSW_C] <= next_cc; // RULE_11
    end
  end

  // Status word as a bus word: high byte is always zero
  assign status_word_ext = {8'h00, o_processor_status_word};

  // Status outputs: zero when not selected, so the read bus can be ORed
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_status_sys_bus_enable <= 1'b0;
    end else begin
      o_status_sys_bus_enable <= i_status_absolute_addr;    // RULE_13
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_status_to_sys_bus <= 16'h0000;
    end else if (i_status_absolute_addr) begin
      o_status_to_sys_bus <= status_word_ext;               // RULE_13
    end else begin
      o_status_to_sys_bus <= 16'h0000;
    end
  end

  // Absolute addressing takes the word off the read bus
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_status_to_read_bus <= 16'h0000;
    end else if (i_status_read_enable && !i_status_absolute_addr) begin
      o_status_to_read_bus <= status_word_ext;              // RULE_15
    end else begin
      o_status_to_read_bus <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// file: verification/read_bus_partner.sv
`timescale 1ns/10ps
`default_nettype none
module read_bus_partner (
  // Scratch-pad side
  input  wire logic        i_scratch_enable,
  input  wire logic [15:0] i_scratch_data,
  // Status side
  input  wire logic [15:0] i_status_to_read_bus,
  // Wired-OR bus
  output logic [15:0]      o_read_bus
);
  // Idle units give zeros so the OR keeps the active value
  assign o_read_bus = (i_scratch_enable ? i_scratch_data : 16'h0000) | i_status_to_read_bus;
endmodule
`default_nettype wire

// file: verification/alu_status_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module alu_status_monitor (
  // Clock and reset
  input wire logic                      i_clk_sys,
  input wire logic                      i_arst_n,
  // Controls
  input wire alu_status_pkg::alu_ctrl_s i_alu_ctrl,
  input wire logic [1:0]                i_dest_select,
  input wire logic [1:0]                i_dmux_select,
  input wire logic [2:0]                i_status_load_select_code,
  input wire alu_status_pkg::cond_codes_s i_decode_cond_codes,
  input wire logic                      i_status_absolute_addr,
  input wire logic                      i_status_read_enable,
  // Data
  input wire logic [15:0]               i_operand_a_input,
  input wire logic [15:0]               i_operand_b_input,
  input wire logic [15:0]               i_read_bus,
  input wire logic [15:0]               i_sys_bus_data,
  // Results
  input wire logic [15:0]               o_data_reg,
  input wire logic [15:0]               o_bus_addr_reg,
  input wire logic [15:0]               o_dmux,
  input wire logic [7:0]                o_processor_status_word,
  input wire logic [15:0]               o_status_to_read_bus
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  logic [7:0] c;
  logic [2:0] s;
  assign c = i_alu_ctrl;
  assign s = i_status_load_select_code;
  a_add_to_data:
    assert property (c[7:3] == 5'h12 && c[1:0] == 2'h0 && i_dest_select == 2'h1 |=> o_data_reg == $past(i_operand_a_input) + $past(i_operand_b_input) + $past(c[2])) else $error("sum not captured");
  a_not_to_addr:
    assert property (c[7:3] == 5'h01 && c[1:0] == 2'h0 && i_dest_select == 2'h2 |=> o_bus_addr_reg == ~$past(i_operand_a_input)) else $error("complement not captured");
  a_dest_none_hold:
    assert property (i_dest_select == 2'h0 |=> $stable(o_data_reg) && $stable(o_bus_addr_reg)) else $error("register changed without select");
  a_psw_whole_load:
    assert property (s == 3'h1 && i_dmux_select == 2'h0 |=> o_processor_status_word == $past(i_read_bus[7:0])) else $error("status not loaded from mux");
  a_psw_hold_code:
    assert property (s == 3'h0 || s > 3'h4 |=> $stable(o_processor_status_word)) else $error("status changed on hold");
  a_cc_from_decode:
    assert property (s == 3'h4 |=> o_processor_status_word == {$past(o_processor_status_word[7:4]), $past(i_decode_cond_codes)}) else $error("decode codes not loaded");
  a_dmux_sys_data:
    assert property (i_dmux_select == 2'h1 |=> o_dmux == $past(i_sys_bus_data)) else $error("mux lost system data");
  a_dmux_shift_right:
    assert property (i_dmux_select[1] |=> o_dmux[14:0] == $past(o_data_reg[15:1])) else $error("mux shift wrong");
  a_status_off_read:
    assert property (!i_status_read_enable || i_status_absolute_addr |=> o_status_to_read_bus == 16'h0000) else $error("status on read bus");
endmodule
bind alu_status_datapath alu_status_monitor mon_u (.*);
`default_nettype wire

// file: verification/tb_alu_and_status_datapath.sv
`timescale 1ns/10ps
`default_nettype none
module tb_alu_and_status_datapath;
  typedef struct packed {logic [2:0] kind; logic [15:0] mask; logic [15:0] exp;} note_s;
  logic i_clk_sys = 1'b0, i_arst_n = 1'b0, i_ir_mode = 1'b0, i_ir_carry_in = 1'b1;
  logic i_status_absolute_addr = 1'b0, i_status_read_enable = 1'b0, scratch_en = 1'b0;
  alu_status_pkg::alu_ctrl_s i_alu_ctrl = '0;
  alu_status_pkg::cond_codes_s i_decode_cond_codes = '0;
  logic [1:0] i_dest_select = 2'h0, i_dmux_select = 2'h0;
  logic [2:0] i_status_load_select_code = 3'h0;
  logic [3:0] i_ir_function_select = 4'h9;
  logic [15:0] i_operand_a_input = 16'h0000, i_operand_b_input = 16'h0000, i_read_bus;
  logic [15:0] i_sys_bus_data = 16'h0000, scratch = 16'h0000;
  logic [15:0] o_data_reg, o_bus_addr_reg, o_dmux, o_status_to_read_bus, o_status_to_sys_bus;
  logic [7:0] o_processor_status_word, pm = 8'h00;
  logic o_status_sys_bus_enable;
  note_s notes[$];
  note_s n;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 58211;
  logic [5:0] fns [14] = '{6'h02, 6'h03, 6'h00, 6'h01, 6'h24, 6'h25, 6'h18,
                           6'h19, 6'h3E, 6'h3F, 6'h3C, 6'h3D, 6'h30, 6'h31};
  alu_status_datapath dut_u (.*);
  read_bus_partner bus_u (.i_scratch_enable(scratch_en), .i_scratch_data(scratch),
                          .i_status_to_read_bus(o_status_to_read_bus), .o_read_bus(i_read_bus));
  always #2.5 i_clk_sys = ~i_clk_sys;
  function automatic logic [15:0] ref_alu(input logic [5:0] f, input logic [15:0] x, y);
    case (f[5:1])
      5'h01: return ~x;
      5'h1F: return x;
      5'h00: return x + f[0];
      5'h12: return x + y + f[0];
      5'h0C: return x - y - 16'h0001 + f[0];
      5'h1E: return x - 16'h0001 + f[0];
      default: return (x << 1) + f[0];
    endcase
  endfunction
  task automatic note(input logic [2:0] k, input logic [15:0] e, m);
    notes.push_back('{k, m, e});
  endtask
  task automatic check_word(input logic [15:0] got, exp, msk);
    samples_checked++;
    if ((got & msk) !== (exp & msk)) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_status(input logic [7:0] got, exp, msk);
    check_word({8'h00, got}, {8'h00, exp}, {8'h00, msk});
  endtask
  task automatic check_flag(input logic got, exp);
    check_word({15'h0000, got}, {15'h0000, exp}, 16'h0001);
  endtask
  task automatic alu_op(input logic [7:0] c, input logic [1:0] d, input logic [15:0] x, y);
    logic [15:0] r;
    i_operand_a_input = x;
    i_operand_b_input = y;
    i_alu_ctrl = c;
    i_dest_select = d;
    r = ref_alu(c[1:0] == 2'h1 ? {i_ir_function_select, i_ir_mode, i_ir_carry_in} : c[7:2], x, y);
    if (d[0]) note(3'h0, r, 16'hFFFF);
    if (d[1]) note(3'h1, r, 16'hFFFF);
    @(negedge i_clk_sys);
  endtask
  task automatic idle_check();
    {i_dest_select, i_status_load_select_code, i_dmux_select, i_sys_bus_data} = '0;
    pm = 8'h00;
    for (int k = 0; k < 5; k++) note(3'(k), 16'h0000, 16'hFFFF);
    @(negedge i_clk_sys);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    #1;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.kind)
        3'h0: check_word(o_data_reg, n.exp, n.mask);
        3'h1: check_word(o_bus_addr_reg, n.exp, n.mask);
        3'h2: check_word(o_dmux, n.exp, n.mask);
        3'h3: check_status(o_processor_status_word, n.exp[7:0], n.mask[7:0]);
        3'h4: check_word(o_status_to_read_bus, n.exp, n.mask);
        3'h5: check_word(o_status_to_sys_bus, n.exp, n.mask);
        default: check_flag(o_status_sys_bus_enable, n.exp[0]);
      endcase
    end
  end
  initial begin
    repeat (16) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    idle_check();
    for (int i = 0; i < 14; i++) begin
      alu_op({fns[i], 2'h0}, 2'(i % 3) + 2'h1, 16'($random(seed)), 16'($random(seed)));
    end
    alu_op(8'h09, 2'h3, 16'($random(seed)), 16'($random(seed)));
    i_status_load_select_code = 3'h2;
    note(3'h3, 16'h0005, 16'h000F);
    alu_op(8'h90, 2'h0, 16'hFFFF, 16'h0001);
    note(3'h3, 16'h000A, 16'h000F);
    alu_op(8'h90, 2'h0, 16'h4000, 16'h4000);
    for (int k = 0; k < 2; k++) begin
      {scratch_en, i_dmux_select, i_status_load_select_code} = {1'b1, 2'(k), 3'h1};
      scratch = 16'($random(seed));
      i_sys_bus_data = 16'($random(seed));
      pm = k ? i_sys_bus_data[7:0] : scratch[7:0];
      note(3'h2, k ? i_sys_bus_data : scratch, 16'hFFFF);
      note(3'h3, {8'h00, pm}, 16'h00FF);
      @(negedge i_clk_sys);
    end
    scratch_en = 1'b0;
    i_status_load_select_code = 3'h3;
    note(3'h3, {8'h00, pm[7:4], 3'h2, pm[0]}, 16'h00FF);
    alu_op(8'h90, 2'h0, 16'hFFFF, 16'h0001);
    pm = {pm[7:4], 3'h2, pm[0]};
    i_status_load_select_code = 3'h4;
    i_decode_cond_codes = 4'($random(seed));
    pm[3:0] = i_decode_cond_codes;
    note(3'h3, {8'h00, pm}, 16'h00FF);
    @(negedge i_clk_sys);
    for (int k = 5; k < 9; k++) begin
      i_status_load_select_code = 3'(k);
      note(3'h3, {8'h00, pm}, 16'h00FF);
      @(negedge i_clk_sys);
    end
    for (int k = 0; k < 2; k++) begin
      {i_status_read_enable, i_status_absolute_addr} = {1'b1, 1'(k)};
      note(3'h4, k ? 16'h0000 : {8'h00, pm}, 16'hFFFF);
      note(3'h5, k ? {8'h00, pm} : 16'h0000, 16'hFFFF);
      note(3'h6, 16'(k), 16'h0001);
      @(negedge i_clk_sys);
    end
    alu_op(8'h90, 2'h1, 16'hFFFF, 16'h0004);
    {i_dest_select, i_dmux_select} = 4'h2;
    note(3'h2, 16'h8001, 16'hFFFF);
    @(negedge i_clk_sys);
    i_dmux_select = 2'h3;
    note(3'h2, 16'h8001, 16'hFFFF);
    @(negedge i_clk_sys);
    i_arst_n = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    idle_check();
    @(negedge i_clk_sys);
    stop_test();
  end
endmodule
`default_nettype wire
